//--- cpf_core.sv
`timescale 1ns/1ns
`default_nettype none
module cpf_core
    import cpf_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // reset cause and mode, taken at the first edge after the synchronised release
    input  wire cpf_cause_e  rst_cause,
    input  wire logic        boot_mode,
    // byte read port
    output logic             mem_rd,
    output logic [15:0]      mem_addr,
    input  wire logic        mem_rvalid,
    input  wire logic [7:0]  mem_rdata,
    // opcode length lookup
    output logic             opc_probe,
    input  wire logic [1:0]  dec_opnd_count,
    // decoded instruction and its execution
    output logic             instr_valid,
    output cpf_instr_s       instr,
    input  wire logic        exe_valid,
    input  wire cpf_exec_s   exe,
    input  wire cpf_flags_s  exe_flags,
    input  wire logic        exe_ptr_load,
    input  wire logic [15:0] exe_ptr,
    output logic [15:0]      alu_result,
    // interrupts and stacking
    input  wire logic        irq_pending,
    input  wire logic        nonmaskable_irq_pin_n,
    input  wire logic [15:0] int_vec_addr,
    output logic             stack_req,
    output logic             stack_nmi,
    input  wire logic        stack_done,
    // low-power stop
    output logic             stop_req,
    input  wire logic        wake,
    // core state
    output logic [15:0]      next_instr_pointer,
    output cpf_flags_s       processor_flags
);

    typedef struct packed {
        cpf_st_e     st;
        cpf_flags_s  flags;
        logic [15:0] ptr;
        logic        mem_rd;
        logic [15:0] mem_addr;
        logic [7:0]  hi;
        cpf_instr_s  ins;
        logic [1:0]  nleft;
        logic        instr_valid;
        logic        probe;
        logic        stack_req;
        logic        nmi_take;
        logic        stop_req;
        logic [15:0] result;
    } cpf_state_s;

    logic [1:0]  rst_sync_ff;
    logic        rst_n;
    cpf_state_s  s_ff;
    cpf_state_s  nxt_s;
    logic        pre_hit;
    logic [1:0]  pre_page;
    logic [15:0] alu_res;
    cpf_flags_s  alu_flags;
    logic        nmi_req;

    // reset release through two stages; assertion is immediate
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    cpf_page_dec u_page_dec (
        .code   (mem_rdata),
        .is_pre (pre_hit),
        .page   (pre_page)
    );

    cpf_flag_alu u_flag_alu (
        .op        (exe),
        .flags_in  (s_ff.flags),
        .result    (alu_res),
        .flags_out (alu_flags)
    );

    assign nmi_req = ~nonmaskable_irq_pin_n & ~s_ff.flags.x;

    always_comb begin
        nxt_s = s_ff;
        unique case (s_ff.st)
            ST_RST: begin
                // cause and mode are sampled here, after release, never at reset
                nxt_s.mem_addr = reset_vector(boot_mode, rst_cause);
                nxt_s.mem_rd = 1'b1;
                nxt_s.st = ST_VEC_HI;
            end
            ST_VEC_HI: begin
                if (mem_rvalid) begin
                    nxt_s.hi = mem_rdata;
                    nxt_s.mem_addr = s_ff.mem_addr + 16'h0001;
                    nxt_s.st = ST_VEC_LO;
                end
            end
            ST_VEC_LO: begin
                if (mem_rvalid) begin
                    nxt_s.ptr = {s_ff.hi, mem_rdata};
                    nxt_s.mem_rd = 1'b0;
                    nxt_s.st = ST_BOUND;
                end
            end
            ST_BOUND: begin
                // nonmaskable first; a masked request just stays pending outside
                if (nmi_req) begin
                    nxt_s.stack_req = 1'b1;
                    nxt_s.nmi_take = 1'b1;
                    nxt_s.st = ST_STACK;
                end else if (irq_pending && !s_ff.flags.i) begin
                    nxt_s.stack_req = 1'b1;
                    nxt_s.st = ST_STACK;
                end else begin
                    nxt_s.mem_rd = 1'b1;
                    nxt_s.mem_addr = s_ff.ptr;
                    nxt_s.ins = '0;
                    nxt_s.st = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (mem_rvalid) begin
                    nxt_s.ptr = s_ff.ptr + 16'h0001;
                    nxt_s.mem_addr = s_ff.ptr + 16'h0001;
                    // only one prebyte: after it any byte is the opcode
                    if (pre_hit && s_ff.ins.page == 2'h0) begin
                        nxt_s.ins.page = pre_page;
                    end else begin
                        nxt_s.ins.opcode = mem_rdata;
                        nxt_s.mem_rd = 1'b0;
                        nxt_s.probe = 1'b1;
                        nxt_s.st = ST_LEN;
                    end
                end
            end
            ST_LEN: begin
                nxt_s.probe = 1'b0;
                nxt_s.ins.nopnd = dec_opnd_count;
                nxt_s.nleft = dec_opnd_count;
                if (dec_opnd_count == 2'h0) begin
                    nxt_s.instr_valid = 1'b1;
                    nxt_s.st = ST_EXEC;
                end else begin
                    nxt_s.mem_rd = 1'b1;
                    nxt_s.st = ST_OPND;
                end
            end
            ST_OPND: begin
                if (mem_rvalid) begin
                    // earlier byte lands higher, so a 16-bit operand reads high first
                    nxt_s.ins.opnd = {s_ff.ins.opnd[15:0], mem_rdata};
                    nxt_s.ptr = s_ff.ptr + 16'h0001;
                    nxt_s.mem_addr = s_ff.ptr + 16'h0001;
                    nxt_s.nleft = s_ff.nleft - 2'h1;
                    if (s_ff.nleft == 2'h1) begin
                        nxt_s.mem_rd = 1'b0;
                        nxt_s.instr_valid = 1'b1;
                        nxt_s.st = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                if (exe_valid) begin
                    nxt_s.instr_valid = 1'b0;
                    nxt_s.result = alu_res;
                    nxt_s.st = ST_BOUND;
                    unique case (exe.kind)
                        EK_FLAGS_LOAD, EK_RETURN: begin
                            // software may clear X but never set it
                            nxt_s.flags = exe_flags;
                            nxt_s.flags.x = s_ff.flags.x & exe_flags.x;
                        end
                        EK_STOP: begin
                            if (!s_ff.flags.s) begin
                                nxt_s.stop_req = 1'b1;
                                nxt_s.st = ST_STOP;
                            end
                        end
                        default: nxt_s.flags = alu_flags;
                    endcase
                    if (exe_ptr_load) begin
                        nxt_s.ptr = exe_ptr;
                    end
                end
            end
            ST_STACK: begin
                if (stack_done) begin
                    nxt_s.stack_req = 1'b0;
                    nxt_s.flags.i = 1'b1;
                    if (s_ff.nmi_take) begin
                        nxt_s.flags.x = 1'b1;
                    end
                    nxt_s.nmi_take = 1'b0;
                    nxt_s.mem_addr = int_vec_addr;
                    nxt_s.mem_rd = 1'b1;
                    nxt_s.st = ST_VEC_HI;
                end
            end
            ST_STOP: begin
                if (wake) begin
                    nxt_s.stop_req = 1'b0;
                    nxt_s.st = ST_BOUND;
                end
            end
            default: nxt_s.st = ST_RST;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_ff <= '0;
            s_ff.st <= ST_RST;
            s_ff.flags <= FLAGS_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign mem_rd = s_ff.mem_rd;
    assign mem_addr = s_ff.mem_addr;
    assign opc_probe = s_ff.probe;
    assign instr_valid = s_ff.instr_valid;
    assign instr = s_ff.ins;
    assign alu_result = s_ff.result;
    assign stack_req = s_ff.stack_req;
    assign stack_nmi = s_ff.nmi_take;
    assign stop_req = s_ff.stop_req;
    assign next_instr_pointer = s_ff.ptr;
    assign processor_flags = s_ff.flags;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_ptr_step;
        (s_ff.st == ST_FETCH || s_ff.st == ST_OPND) && mem_rvalid
            |=> s_ff.ptr == $past(s_ff.ptr) + 16'h0001;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance");

    property p_vec_norm;
        s_ff.st == ST_RST && !boot_mode && rst_cause == RC_WDOG
            |=> mem_rd && mem_addr == 16'hFFFA;
    endproperty
    a_vec_norm: assert property (p_vec_norm) else $error("wrong normal vector");

    property p_vec_boot;
        s_ff.st == ST_RST && boot_mode && rst_cause == RC_CLKMON
            |=> mem_rd && mem_addr == 16'hBFFC;
    endproperty
    a_vec_boot: assert property (p_vec_boot) else $error("wrong boot vector");

    property p_noflags;
        s_ff.st == ST_EXEC && exe_valid && exe.kind == EK_NOFLAGS
            |=> processor_flags == $past(processor_flags);
    endproperty
    a_noflags: assert property (p_noflags) else $error("flags changed");

    property p_index_zero;
        s_ff.st == ST_EXEC && exe_valid && exe.kind == EK_INDEX
            |=> {processor_flags[7:3], processor_flags[1:0]}
                == {$past(processor_flags[7:3]), $past(processor_flags[1:0])}
                && processor_flags.z == ($past(exe.a) == 16'h0000);
    endproperty
    a_index_zero: assert property (p_index_zero) else $error("index op flags");

    property p_irq_masked;
        s_ff.st == ST_BOUND && processor_flags.i && !nmi_req |=> !stack_req;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked irq taken");

    property p_i_after_stack;
        stack_req && stack_done |=> processor_flags.i && !stack_req && mem_rd
            && mem_addr == $past(int_vec_addr);
    endproperty
    a_i_after_stack: assert property (p_i_after_stack) else $error("I not set");

    property p_both_masks;
        stack_req && stack_nmi && stack_done |=> processor_flags.i && processor_flags.x;
    endproperty
    a_both_masks: assert property (p_both_masks) else $error("masks not set");

    property p_x_sticky;
        s_ff.st == ST_EXEC && exe_valid && !processor_flags.x
            && (exe.kind == EK_FLAGS_LOAD || exe.kind == EK_RETURN)
            |=> !processor_flags.x;
    endproperty
    a_x_sticky: assert property (p_x_sticky) else $error("X set by software");

    property p_stop_skip;
        s_ff.st == ST_EXEC && exe_valid && exe.kind == EK_STOP && processor_flags.s
            |=> s_ff.st == ST_BOUND && !stop_req;
    endproperty
    a_stop_skip: assert property (p_stop_skip) else $error("stop not skipped");

    property p_word_order;
        s_ff.st == ST_VEC_LO && mem_rvalid
            |=> next_instr_pointer == {$past(s_ff.hi), $past(mem_rdata)};
    endproperty
    a_word_order: assert property (p_word_order) else $error("word byte order");

    c_prebyte: cover property (s_ff.st == ST_LEN && instr.page != 2'h0);
    c_three_opnd: cover property (instr_valid && instr.nopnd == 2'h3);
    c_nmi_taken: cover property (stack_req && stack_nmi && stack_done);
    c_stopped: cover property (stop_req && wake);

endmodule : cpf_core
`default_nettype wire

//--- cpf_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cpf_core_tb
    import cpf_pkg::*;
;
    logic        clk = 1'b0;
    logic        rstn;
    cpf_cause_e  rst_cause;
    logic        boot_mode;
    logic        mem_rd;
    logic [15:0] mem_addr;
    logic        mem_rvalid;
    logic [7:0]  mem_rdata;
    logic        opc_probe;
    logic [1:0]  dec_opnd_count;
    logic        instr_valid;
    cpf_instr_s  instr;
    logic        exe_valid;
    cpf_exec_s   exe;
    cpf_flags_s  exe_flags;
    logic        exe_ptr_load;
    logic [15:0] exe_ptr;
    logic [15:0] alu_result;
    logic        irq_pending;
    logic        nonmaskable_irq_pin_n;
    logic [15:0] int_vec_addr;
    logic        stack_req;
    logic        stack_nmi;
    logic        stack_done;
    logic        stop_req;
    logic        wake;
    logic [15:0] next_instr_pointer;
    cpf_flags_s  processor_flags;
    logic [7:0]  mem [0:65535];
    logic [15:0] want;
    int          err_total = 0;
    int          checked = 0;

    cpf_core u_cpf_core (.clk(clk), .rstn(rstn), .rst_cause(rst_cause),
        .boot_mode(boot_mode), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .opc_probe(opc_probe),
        .dec_opnd_count(dec_opnd_count), .instr_valid(instr_valid), .instr(instr),
        .exe_valid(exe_valid), .exe(exe), .exe_flags(exe_flags),
        .exe_ptr_load(exe_ptr_load), .exe_ptr(exe_ptr), .alu_result(alu_result),
        .irq_pending(irq_pending), .nonmaskable_irq_pin_n(nonmaskable_irq_pin_n),
        .int_vec_addr(int_vec_addr), .stack_req(stack_req), .stack_nmi(stack_nmi),
        .stack_done(stack_done), .stop_req(stop_req), .wake(wake),
        .next_instr_pointer(next_instr_pointer), .processor_flags(processor_flags));

    always #5 clk = ~clk;

    // answer every other cycle so each byte is taken by its own edge
    always @(posedge clk) begin
        #1;
        mem_rvalid = mem_rd && !mem_rvalid;
        mem_rdata = mem[mem_addr];
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // 0 instr_valid, 1 stack_req, 2 mem_rd, 3 pointer equals want, 4 opc_probe
    task automatic wait_hi(input int sel);
        int k;
        k = 0;
        while (!((sel == 0 && instr_valid === 1'b1) || (sel == 1 && stack_req === 1'b1) ||
                 (sel == 2 && mem_rd === 1'b1) || (sel == 3 && next_instr_pointer === want) ||
                 (sel == 4 && opc_probe === 1'b1))
               && k < 60) begin
            step(1);
            k++;
        end
        if (k >= 60) begin
            err_total++;
            $display("CHECK FAILED wait %0d expected 1 seen 0", sel);
            print_verdict();
        end
    endtask : wait_hi

    task automatic do_reset(input cpf_cause_e c, input logic b);
        rstn = 1'b0;
        rst_cause = c;
        boot_mode = b;
        step(12);
        chk("flags_in_reset", {8'h00, processor_flags}, 16'h00D0);
        rstn = 1'b1;
    endtask : do_reset

    task automatic run(input cpf_kind_e k, input logic [15:0] a, input logic [7:0] fexp);
        wait_hi(0);
        exe.kind = k;
        exe.a = a;
        exe.b = 16'h0000;
        if (k == EK_ADD) begin
            exe.b = 16'h0008;
        end
        if (k == EK_SUB) begin
            exe.b = 16'h0001;
        end
        exe_valid = 1'b1;
        step(1);
        exe_valid = 1'b0;
        chk("flags", {8'h00, processor_flags}, {8'h00, fexp});
    endtask : run

    task automatic t_vectors();
        logic [15:0] v;
        for (int i = 0; i < 6; i++) begin
            v = ((i >= 3) ? 16'hBFFE : 16'hFFFE) - 16'(2 * (i % 3));
            mem[v] = 8'h40 + 8'(i);
            mem[v + 16'h0001] = 8'h10;
            want = {8'h40 + 8'(i), 8'h10};
            do_reset(cpf_cause_e'(i % 3), i >= 3);
            wait_hi(2);
            chk("vector_addr", mem_addr, v);
            wait_hi(3);
            chk("vector_load", next_instr_pointer, want);
        end
    endtask : t_vectors

    // prebyte for page 2, then opcode with two operand bytes
    task automatic t_fetch();
        mem[16'h4010] = PRE_PAGE2;
        mem[16'h4011] = 8'h5C;
        mem[16'h4012] = 8'hAA;
        mem[16'h4013] = 8'hBB;
        dec_opnd_count = 2'h2;
        do_reset(RC_POR_PIN, 1'b0);
        wait_hi(4);
        chk("page", 16'(instr.page), 16'h0002);
        chk("opcode", 16'(instr.opcode), 16'h005C);
        step(1);
        chk("probe_pulse", 16'(opc_probe), 16'h0000);
        wait_hi(0);
        chk("nopnd", 16'(instr.nopnd), 16'h0002);
        chk("opnd", instr.opnd[15:0], 16'hAABB);
        chk("pointer", next_instr_pointer, 16'h4014);
        dec_opnd_count = 2'h0;
    endtask : t_fetch

    task automatic t_flags();
        run(EK_ADD, 16'h0008, 8'hF0);
        chk("add_result", alu_result, 16'h0010);
        run(EK_INDEX, 16'h0000, 8'hF4);
        run(EK_SUB, 16'h0000, 8'hF9);
        run(EK_NOFLAGS, 16'h0000, 8'hF9);
        run(EK_DATA, 16'h0000, 8'hF5);
        run(EK_SHL, 16'h0080, 8'hF7);
        run(EK_STOP, 16'h0000, 8'hF7);
        step(3);
        chk("stop_disabled", 16'(stop_req), 16'h0000);
    endtask : t_flags

    task automatic t_irq();
        irq_pending = 1'b1;
        run(EK_NOFLAGS, 16'h0000, 8'hF7);
        step(4);
        chk("masked_irq", 16'(stack_req), 16'h0000);
        exe_flags = 8'h00;
        run(EK_FLAGS_LOAD, 16'h0000, 8'h00);
        wait_hi(1);
        chk("irq_kind", 16'(stack_nmi), 16'h0000);
        int_vec_addr = 16'h5000;
        irq_pending = 1'b0;
        nonmaskable_irq_pin_n = 1'b0;
        stack_done = 1'b1;
        step(1);
        stack_done = 1'b0;
        chk("irq_mask_set", 16'(processor_flags.i), 16'h0001);
        chk("irq_vec_fetch", mem_addr, 16'h5000);
        wait_hi(1);
        chk("nmi_kind", 16'(stack_nmi), 16'h0001);
        chk("x_before_ack", 16'(processor_flags.x), 16'h0000);
        stack_done = 1'b1;
        nonmaskable_irq_pin_n = 1'b1;
        step(1);
        stack_done = 1'b0;
        chk("nmi_masks", 16'({processor_flags.x, processor_flags.i}), 16'h0003);
    endtask : t_irq

    // return reloads flags and pointer; software may clear X but never set it
    task automatic t_return();
        exe_flags = 8'h01;
        exe_ptr = 16'h6000;
        exe_ptr_load = 1'b1;
        run(EK_RETURN, 16'h0000, 8'h01);
        exe_ptr_load = 1'b0;
        chk("return_ptr", next_instr_pointer, 16'h6000);
        exe_flags = 8'h40;
        run(EK_FLAGS_LOAD, 16'h0000, 8'h00);
    endtask : t_return

    // carry chains from one shift into the next; then error, wide add and stop
    task automatic t_ops();
        run(EK_SHL, 16'h0080, 8'h07);
        exe.use_c = 1'b1;
        run(EK_SHR, 16'h0002, 8'h0A);
        chk("shift_chain", alu_result, 16'h0081);
        exe.use_c = 1'b0;
        exe.err = 1'b1;
        run(EK_MULDIV, 16'h0000, 8'h0B);
        exe.err = 1'b0;
        exe.wide = 1'b1;
        run(EK_ADD, 16'h7FF8, 8'h0A);
        chk("wide_add", alu_result, 16'h8000);
        exe.wide = 1'b0;
        run(EK_STOP, 16'h0000, 8'h0A);
        chk("stop_entered", 16'(stop_req), 16'h0001);
        wake = 1'b1;
        step(1);
        wake = 1'b0;
        chk("stop_woken", 16'(stop_req), 16'h0000);
    endtask : t_ops

    initial begin
        rstn = 1'b0;
        rst_cause = RC_POR_PIN;
        boot_mode = 1'b0;
        mem_rvalid = 1'b0;
        mem_rdata = 8'h00;
        dec_opnd_count = 2'h0;
        exe_valid = 1'b0;
        exe = '0;
        exe_flags = 8'h00;
        exe_ptr_load = 1'b0;
        exe_ptr = 16'h0000;
        irq_pending = 1'b0;
        nonmaskable_irq_pin_n = 1'b1;
        int_vec_addr = 16'h0000;
        stack_done = 1'b0;
        wake = 1'b0;
        want = 16'h0000;
        for (int a = 0; a < 65536; a++) begin
            mem[a] = 8'h01;
        end
        #1;
        t_vectors();
        t_fetch();
        t_flags();
        t_irq();
        t_return();
        t_ops();
        print_verdict();
    end
endmodule : cpf_core_tb
`default_nettype wire

//--- cpf_flag_alu.sv
`timescale 1ns/1ns
`default_nettype none
module cpf_flag_alu
    import cpf_pkg::*;
(
    // operation in
    input  wire cpf_exec_s  op,
    input  wire cpf_flags_s flags_in,
    // result out
    output logic [15:0]     result,
    output cpf_flags_s      flags_out
);

    function automatic logic top_bit(input logic [15:0] v, input logic wide);
        return wide ? v[15] : v[7];
    endfunction : top_bit

    logic [15:0] msk;
    logic [15:0] am;
    logic [15:0] bm;
    logic [16:0] sum;
    logic [4:0]  half;
    logic        cin;

    always_comb begin
        msk = op.wide ? 16'hFFFF : 16'h00FF;
        am = op.a & msk;
        bm = op.b & msk;
        cin = op.use_c & flags_in.c;
        sum = 17'h0_0000;
        half = {1'b0, am[3:0]} + {1'b0, bm[3:0]} + {4'h0, cin};
        result = am;
        flags_out = flags_in;
        unique case (op.kind)
            EK_ADD: begin
                sum = {1'b0, am} + {1'b0, bm} + {16'h0000, cin};
                result = sum[15:0] & msk;
                flags_out.c = op.wide ? sum[16] : sum[8];
                flags_out.v = (top_bit(am, op.wide) == top_bit(bm, op.wide))
                    && (top_bit(result, op.wide) != top_bit(am, op.wide));
                flags_out.h = op.wide ? flags_in.h : half[4];
            end
            EK_SUB: begin
                // compares use this path too; the caller discards the result
                sum = {1'b0, am} - {1'b0, bm} - {16'h0000, cin};
                result = sum[15:0] & msk;
                flags_out.c = op.wide ? sum[16] : sum[8];
                flags_out.v = (top_bit(am, op.wide) != top_bit(bm, op.wide))
                    && (top_bit(result, op.wide) != top_bit(am, op.wide));
            end
            EK_SHL: begin
                result = {am[14:0], cin} & msk;
                flags_out.c = top_bit(am, op.wide);
                flags_out.v = top_bit(result, op.wide) ^ flags_out.c;
            end
            EK_SHR: begin
                result = op.wide ? {cin, am[15:1]} : {8'h00, cin, am[7:1]};
                flags_out.c = am[0];
                flags_out.v = top_bit(result, op.wide) ^ flags_out.c;
            end
            EK_DATA: flags_out.v = 1'b0;
            EK_MULDIV: flags_out.c = op.err;
            // index registers are always 16 bits, whatever the width bit says
            EK_INDEX: flags_out.z = (op.a == 16'h0000);
            default: ;
        endcase
        if (op.kind inside {EK_ADD, EK_SUB, EK_SHL, EK_SHR, EK_DATA}) begin
            flags_out.n = top_bit(result, op.wide);
            flags_out.z = (result == 16'h0000);
        end
    end

endmodule : cpf_flag_alu
`default_nettype wire

//--- cpf_page_dec.sv
`timescale 1ns/1ns
`default_nettype none
module cpf_page_dec
    import cpf_pkg::*;
(
    // fetched byte
    input  wire logic [7:0] code,
    // page selection
    output logic            is_pre,
    output logic [1:0]      page
);

    always_comb begin
        is_pre = 1'b1;
        unique case (code)
            PRE_PAGE1: page = 2'h1;
            PRE_PAGE2: page = 2'h2;
            PRE_PAGE3: page = 2'h3;
            default: begin
                is_pre = 1'b0;
                page = 2'h0;
            end
        endcase
    end

endmodule : cpf_page_dec
`default_nettype wire

//--- cpf_pkg.sv
`default_nettype none
package cpf_pkg;

    // reset vectors, normal mode
    localparam logic [15:0] VEC_NORM_POR = 16'hFFFE;
    localparam logic [15:0] VEC_NORM_CKM = 16'hFFFC;
    localparam logic [15:0] VEC_NORM_WDG = 16'hFFFA;
    // reset vectors, test or boot mode
    localparam logic [15:0] VEC_BOOT_POR = 16'hBFFE;
    localparam logic [15:0] VEC_BOOT_CKM = 16'hBFFC;
    localparam logic [15:0] VEC_BOOT_WDG = 16'hBFFA;

    // prebytes selecting opcode pages 1..3
    localparam logic [7:0] PRE_PAGE1 = 8'h18;
    localparam logic [7:0] PRE_PAGE2 = 8'h1A;
    localparam logic [7:0] PRE_PAGE3 = 8'hCD;

    // flags after any reset: stop-disable and both masks set
    localparam logic [7:0] FLAGS_RST = 8'hD0;

    // bit 7 down to bit 0 of processor_flags
    typedef struct packed {
        logic s;
        logic x;
        logic h;
        logic i;
        logic n;
        logic z;
        logic v;
        logic c;
    } cpf_flags_s;

    typedef enum logic [1:0] {RC_POR_PIN, RC_CLKMON, RC_WDOG} cpf_cause_e;

    typedef enum logic [3:0] {
        EK_NOFLAGS, EK_ADD, EK_SUB, EK_DATA, EK_SHL, EK_SHR,
        EK_MULDIV, EK_INDEX, EK_FLAGS_LOAD, EK_RETURN, EK_STOP
    } cpf_kind_e;

    typedef struct packed {
        cpf_kind_e   kind;
        logic        wide;
        logic        use_c;
        logic        err;
        logic [15:0] a;
        logic [15:0] b;
    } cpf_exec_s;

    typedef struct packed {
        logic [1:0]  page;
        logic [7:0]  opcode;
        logic [1:0]  nopnd;
        logic [23:0] opnd;
    } cpf_instr_s;

    typedef enum logic [3:0] {
        ST_RST, ST_VEC_HI, ST_VEC_LO, ST_BOUND, ST_FETCH,
        ST_LEN, ST_OPND, ST_EXEC, ST_STACK, ST_STOP
    } cpf_st_e;

    function automatic logic [15:0] reset_vector(input logic boot, input cpf_cause_e cause);
        logic [15:0] v;
        v = boot ? VEC_BOOT_POR : VEC_NORM_POR;
        if (cause == RC_CLKMON) begin
            v = boot ? VEC_BOOT_CKM : VEC_NORM_CKM;
        end else if (cause == RC_WDOG) begin
            v = boot ? VEC_BOOT_WDG : VEC_NORM_WDG;
        end
        return v;
    endfunction : reset_vector

endpackage : cpf_pkg
`default_nettype wire
